// file: dv/cpa_host_model.sv
/*
 Host processor model: drives selects and one-cycle strobes at the
 falling edge and samples read data once it has settled.
 Assumes strobes are taken on the rising edge of clk_sys.
*/
`include "cpa_defines.svh"
module cpa_host_model (
   // clock
   input wire logic clk_sys,
   // processor port
   output logic reg_select_bit2,
   output logic reg_select_bit1,
   output logic reg_select_bit0,
   output logic cpu_wr,
   output logic cpu_rd,
   output logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {reg_select_bit2, reg_select_bit1, reg_select_bit0} = 3'h0;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_wdata = 8'h00;
   end
   // two idle cycles after each access cover the holding reload
   task automatic access(input logic w, input logic [2:0] sel,
         input logic [7:0] d, output logic [7:0] q);
      @(negedge clk_sys);
      {reg_select_bit2, reg_select_bit1, reg_select_bit0} = sel;
      cpu_wdata = d;
      cpu_wr = w;
      cpu_rd = !w;
      @(negedge clk_sys);
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      // released data bus must not keep its last value
      cpu_wdata = ~d;
      @(negedge clk_sys);
      q = cpu_rdata;
      @(negedge clk_sys);
   endtask
   task automatic write_rgb(input logic [23:0] c);
      logic [7:0] q;
      for (int j = 2; j >= 0; j--)
         access(1'b1, `CPA_SEL_HOLD, c[j*8 +: 8], q);
   endtask
endmodule

// file: dv/cpa_top_test.sv
/*
 Self-checking bench for the palette block: fills the palette through
 the host model, reads it back, then checks pixel lookups.
 Assumes the host model in dv/ and the design files in hdl/.
*/
`include "cpa_defines.svh"
module cpa_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst, rs2, rs1, rs0, cpu_wr, cpu_rd;
   logic mode_8bit, direct_colour, dot_en;
   logic [7:0] cpu_wdata, cpu_rdata, pixel_in, pointer_out, q;
   logic [23:0] dac_data, test_data, c;
   logic [15:0] crc_value, crc_exp;
   cpa_pkg::cpa_planes_t planes;
   int bad_count = 0;
   int n_checks = 0;
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   cpa_top DUT (.clk_sys(clk_sys), .rst(rst),
      .reg_select_bit2(rs2), .reg_select_bit1(rs1),
      .reg_select_bit0(rs0), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .mode_8bit(mode_8bit), .direct_colour(direct_colour),
      .planes(planes), .dot_en(dot_en), .pixel_in(pixel_in),
      .dac_data(dac_data), .test_data(test_data), .crc_value(crc_value),
      .pointer_out(pointer_out));
   cpa_host_model host (.clk_sys(clk_sys), .reg_select_bit2(rs2),
      .reg_select_bit1(rs1), .reg_select_bit0(rs0), .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
   function automatic logic [23:0] col(input logic [7:0] a);
      return {a, ~a, a ^ 8'h5A};
   endfunction
   function automatic logic [23:0] six(input logic [23:0] v);
      return {v[21:16], 2'h0, v[13:8], 2'h0, v[5:0], 2'h0};
   endfunction
   function automatic logic [15:0] crc_fold(input logic [15:0] r,
         input logic [23:0] v);
      logic [15:0] s;
      s = (r << 1) ^ (16'h1021 & {16{r[15]}});
      return s ^ {v[23:16], v[15:8] ^ v[7:0]};
   endfunction
   function automatic logic [7:0] addr_of(input logic [7:0] p, m, g,
         input logic [1:0] pl, input logic dc);
      logic [7:0] a;
      a = dc ? p : p & m;
      case (pl)
         2'h1: a = {g[7:4], a[3:0]};
         2'h2: a = {g[7:2], a[1:0]};
         2'h3: a = {g[7:1], a[0]};
         default: a = a;
      endcase
      return a;
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      host.access(1'b1, sel, d, q);
   endtask
   task automatic rd(input logic [2:0] sel);
      host.access(1'b0, sel, 8'h00, q);
   endtask
   task automatic rd_rgb(input logic [23:0] exp);
      for (int j = 2; j >= 0; j--) begin
         rd(`CPA_SEL_HOLD);
         chk(24'(q), 24'(exp[j*8 +: 8]));
      end
   endtask
   task automatic look(input logic [7:0] pix, input logic [23:0] exp);
      @(negedge clk_sys);
      pixel_in = pix;
      repeat (2) @(negedge clk_sys);
      dot_en = 1'b1;
      @(negedge clk_sys);
      dot_en = 1'b0;
      @(negedge clk_sys);
      chk(dac_data, exp);
      chk(test_data, exp);
      crc_exp = crc_fold(crc_exp, exp);
      chk(24'(crc_value), 24'(crc_exp));
   endtask
   // whole run is about 3300 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      results();
   end
   initial begin
      rst = 1'b1;
      mode_8bit = 1'b1;
      direct_colour = 1'b0;
      planes = cpa_pkg::CPA_PLANES_8;
      dot_en = 1'b0;
      pixel_in = 8'h00;
      crc_exp = 16'h0000;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      chk(24'(pointer_out), 24'h0);
      rd(`CPA_SEL_MASK);
      chk(24'(q), 24'hFF);
      rd(`CPA_SEL_PAGE);
      chk(24'(q), 24'h0);
      wr(3'h5, 8'h77);
      rd(3'h5);
      chk(24'(q), 24'h0);
      wr(`CPA_SEL_PTR_WR, 8'h00);
      for (int i = 0; i < 256; i++) begin
         if (i == 16)
            chk(24'(pointer_out), 24'h10);
         host.write_rgb(col(i[7:0]));
      end
      chk(24'(pointer_out), 24'h0);
      rd(`CPA_SEL_PTR_WR);
      chk(24'(q), 24'h0);
      // half-written triple must not reach the palette
      wr(`CPA_SEL_PTR_WR, 8'h40);
      wr(`CPA_SEL_HOLD, 8'hAA);
      wr(`CPA_SEL_PTR_WR, 8'h41);
      host.write_rgb(col(8'h41));
      wr(`CPA_SEL_PTR_RD, 8'hFF);
      chk(24'(pointer_out), 24'h0);
      rd_rgb(col(8'hFF));
      rd_rgb(col(8'h00));
      chk(24'(pointer_out), 24'h2);
      rd(`CPA_SEL_PTR_RD);
      chk(24'(q), 24'h2);
      wr(`CPA_SEL_PTR_RD, 8'h80);
      rd(`CPA_SEL_HOLD);
      wr(`CPA_SEL_PTR_RD, 8'h80);
      rd_rgb(col(8'h80));
      mode_8bit = 1'b0;
      wr(`CPA_SEL_PTR_RD, 8'h40);
      rd_rgb(col(8'h40) & 24'h3F3F3F);
      mode_8bit = 1'b1;
      wr(`CPA_SEL_PTR_RD, 8'h40);
      rd_rgb(col(8'h40));
      rd_rgb(col(8'h41));
      wr(`CPA_SEL_MASK, 8'h96);
      wr(`CPA_SEL_PAGE, 8'hA5);
      for (int k = 0; k < 16; k++) begin
         planes = cpa_pkg::cpa_planes_t'(k[1:0]);
         direct_colour = k[2];
         mode_8bit = !k[3];
         c = col(addr_of(8'h7B, 8'h96, 8'hA5, k[1:0], k[2]));
         look(8'h7B, mode_8bit ? c : six(c));
      end
      planes = cpa_pkg::CPA_PLANES_8;
      direct_colour = 1'b1;
      mode_8bit = 1'b1;
      wr(`CPA_SEL_PTR_RD, 8'h41);
      fork
         rd_rgb(col(8'h41));
         look(8'hC3, col(8'hC3));
      join
      results();
   end
endmodule

// file: hdl/cpa_defines.svh
/*
 Constants for the colour palette access block: register selects,
 reset values and palette depth.
 Assumes inclusion by bare name from the design and bench files.
*/
`ifndef CPA_DEFINES_SVH
`define CPA_DEFINES_SVH
`define CPA_SEL_PTR_WR 3'h0
`define CPA_SEL_HOLD 3'h1
`define CPA_SEL_MASK 3'h2
`define CPA_SEL_PTR_RD 3'h3
`define CPA_SEL_PAGE 3'h4
`define CPA_MASK_RESET 8'hFF
`define CPA_PAGE_RESET 8'h00
`define CPA_PTR_RESET 8'h00
`define CPA_DEPTH 256
`endif

// file: hdl/cpa_pkg.sv
/*
 Types shared by the colour palette access block.
 Assumes cpa_defines.svh is on the include path.
*/
package cpa_pkg;
   typedef enum logic [1:0] {
      CPA_RED,
      CPA_GREEN,
      CPA_BLUE
   } cpa_comp_t;
   typedef enum logic [1:0] {
      CPA_PLANES_8,
      CPA_PLANES_4,
      CPA_PLANES_2,
      CPA_PLANES_1
   } cpa_planes_t;
endpackage

// file: hdl/cpa_ram.sv
/*
 Dual-port 256 x 24 palette memory: one write/read port for the
 processor side, one read-only port for the pixel lookup.
 Assumes a single clock; read data are registered one cycle late.
*/
module cpa_ram (
   // clock
   input wire logic clk_sys,
   // processor port
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [23:0] wr_data,
   input wire logic [7:0] rd_addr_a,
   output logic [23:0] rd_data_a,
   // pixel port
   input wire logic [7:0] rd_addr_b,
   output logic [23:0] rd_data_b
);
   logic [23:0] mem [0:255];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // independent pixel port: host traffic never stalls video
   always_ff @(posedge clk_sys) begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
   end
endmodule

// file: hdl/cpa_top.sv
/*
 Colour palette access: processor port with auto-incrementing pointer,
 red/green/blue holding register, pixel lookup with mask and page
 insertion, 6/8-bit output multiplexer feeding DAC, test and CRC taps.
 Assumes processor strobes are single-cycle and synchronous to clk_sys,
 and one clk_sys cycle fits inside one dot clock.
*/
`include "cpa_defines.svh"

// Functional notes
// - 8-bit pointer auto-increments after each transfer
// - pointer wraps from last location to 0
// - host accesses finish within one dot clock
// - entries hold 24 bits, three 8-bit components
// - 6-bit mode reads back MSBs as zero
// - 6-bit output shifts left, LSBs zero
// - test and CRC taps follow output mux
// - blue write stores word and advances pointer
// - read-mode address write loads holding, increments
// - after blue read reload holding and increment
// - dual-port RAM keeps video lookup undisturbed
// - page bits fill missing upper address bits
// - four planes: page bits 7..4 on top
// - page bits inserted after the read mask
// - page fills overlay planes in direct colour
// - pseudo-colour pixel bits ANDed with mask
// - selects 000/001/010/011 decode as documented
module cpa_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // processor port
   input wire logic reg_select_bit2,
   input wire logic reg_select_bit1,
   input wire logic reg_select_bit0,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   // mode controls
   input wire logic mode_8bit,
   input wire logic direct_colour,
   input wire cpa_pkg::cpa_planes_t planes,
   // pixel port
   input wire logic dot_en,
   input wire logic [7:0] pixel_in,
   // colour, crc and pointer outputs
   output logic [23:0] dac_data,
   output logic [23:0] test_data,
   output logic [15:0] crc_value,
   output logic [7:0] pointer_out
);
   logic [2:0] sel;
   logic [7:0] palette_pointer_reg;
   logic [7:0] pixel_plane_mask_reg;
   logic [7:0] palette_page_select_reg;
   cpa_pkg::cpa_comp_t comp_reg;
   logic [23:0] hold_reg;
   logic [15:0] wbuf_reg;
   logic load_pend_reg;
   logic hold_load_reg;
   logic ram_wr;
   logic [23:0] ram_rd_a;
   logic [23:0] ram_rd_b;
   logic [7:0] masked;
   logic [7:0] lookup_addr;
   logic [23:0] mux_out;
   logic wr_ptr_any;
   logic hold_wr;
   logic hold_rd;
   logic [7:0] comp_byte;
   logic [15:0] crc_next;

   assign sel = {reg_select_bit2, reg_select_bit1, reg_select_bit0};
   assign wr_ptr_any = cpu_wr &&
      (sel == `CPA_SEL_PTR_WR || sel == `CPA_SEL_PTR_RD);
   assign hold_wr = cpu_wr && sel == `CPA_SEL_HOLD;
   assign hold_rd = cpu_rd && sel == `CPA_SEL_HOLD;
   assign ram_wr = hold_wr && comp_reg == cpa_pkg::CPA_BLUE;

   // pointer: RAM read issued with current pointer, then incremented
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         palette_pointer_reg <= `CPA_PTR_RESET;
      end else if (cpu_wr && sel == `CPA_SEL_PTR_WR) begin
         palette_pointer_reg <= cpu_wdata;
      end else if (cpu_wr && sel == `CPA_SEL_PTR_RD) begin
         // read mode: pointer loaded now, entry fetched and pointer moved on next cycle
         palette_pointer_reg <= cpu_wdata;
      end else if (ram_wr || load_pend_reg) begin
         // 8-bit add wraps 255 to 0 naturally
         palette_pointer_reg <= palette_pointer_reg + 8'h01;
      end
   end

   // fetch pending, then holding load a cycle later: ram read data are
   // registered, so loading on the fetch cycle would take a stale entry
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         load_pend_reg <= 1'b0;
         hold_load_reg <= 1'b0;
      end else begin
         load_pend_reg <= (cpu_wr && sel == `CPA_SEL_PTR_RD) ||
            (hold_rd && comp_reg == cpa_pkg::CPA_BLUE);
         hold_load_reg <= load_pend_reg;
      end
   end

   // component sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         comp_reg <= cpa_pkg::CPA_RED;
      end else if (wr_ptr_any) begin
         comp_reg <= cpa_pkg::CPA_RED;
      end else if (hold_wr || hold_rd) begin
         case (comp_reg)
            cpa_pkg::CPA_RED: comp_reg <= cpa_pkg::CPA_GREEN;
            cpa_pkg::CPA_GREEN: comp_reg <= cpa_pkg::CPA_BLUE;
            default: comp_reg <= cpa_pkg::CPA_RED;
         endcase
      end
   end

   // red and green bytes wait here until blue arrives
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wbuf_reg <= 16'h0000;
      end else if (hold_wr && comp_reg == cpa_pkg::CPA_RED) begin
         wbuf_reg[15:8] <= cpu_wdata;
      end else if (hold_wr && comp_reg == cpa_pkg::CPA_GREEN) begin
         wbuf_reg[7:0] <= cpu_wdata;
      end
   end

   // holding register reload from the processor RAM port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold_reg <= 24'h000000;
      end else if (hold_load_reg) begin
         hold_reg <= ram_rd_a;
      end
   end

   // mask and page registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pixel_plane_mask_reg <= `CPA_MASK_RESET;
         palette_page_select_reg <= `CPA_PAGE_RESET;
      end else if (cpu_wr && sel == `CPA_SEL_MASK) begin
         pixel_plane_mask_reg <= cpu_wdata;
      end else if (cpu_wr && sel == `CPA_SEL_PAGE) begin
         palette_page_select_reg <= cpu_wdata;
      end
   end

   always_comb begin
      case (comp_reg)
         cpa_pkg::CPA_RED: comp_byte = hold_reg[23:16];
         cpa_pkg::CPA_GREEN: comp_byte = hold_reg[15:8];
         default: comp_byte = hold_reg[7:0];
      endcase
      if (!mode_8bit) begin
         comp_byte[7:6] = 2'b00;
      end
   end

   // registered readback; unmapped selects read zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_rd) begin
         case (sel)
            `CPA_SEL_PTR_WR: cpu_rdata <= palette_pointer_reg;
            `CPA_SEL_PTR_RD: cpu_rdata <= palette_pointer_reg;
            `CPA_SEL_HOLD: cpu_rdata <= comp_byte;
            `CPA_SEL_MASK: cpu_rdata <= pixel_plane_mask_reg;
            `CPA_SEL_PAGE: cpu_rdata <= palette_page_select_reg;
            default: cpu_rdata <= 8'h00;
         endcase
      end
   end

   // pixel address: mask first, page bits after
   always_comb begin
      // direct colour overlay is never masked
      masked = direct_colour ? pixel_in :
         (pixel_in & pixel_plane_mask_reg);
      case (planes)
         cpa_pkg::CPA_PLANES_4:
            lookup_addr = {palette_page_select_reg[7:4], masked[3:0]};
         cpa_pkg::CPA_PLANES_2:
            lookup_addr = {palette_page_select_reg[7:2], masked[1:0]};
         cpa_pkg::CPA_PLANES_1:
            lookup_addr = {palette_page_select_reg[7:1], masked[0]};
         default: lookup_addr = masked;
      endcase
   end

   // whole transfer takes three clk_sys cycles, well inside a dot clock
   cpa_ram u_ram (
      .clk_sys(clk_sys),
      .wr_en(ram_wr),
      .wr_addr(palette_pointer_reg),
      .wr_data({wbuf_reg, cpu_wdata}),
      .rd_addr_a(palette_pointer_reg),
      .rd_data_a(ram_rd_a),
      .rd_addr_b(lookup_addr),
      .rd_data_b(ram_rd_b)
   );

   assign mux_out = mode_8bit ? ram_rd_b :
      {ram_rd_b[21:16], 2'b00, ram_rd_b[13:8], 2'b00,
       ram_rd_b[5:0], 2'b00};

   // simple 16-bit crc folded over the mux output, per dot
   assign crc_next = {crc_value[14:0], 1'b0} ^
      (crc_value[15] ? 16'h1021 : 16'h0000) ^
      mux_out[23:8] ^ {8'h00, mux_out[7:0]};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dac_data <= 24'h000000;
         test_data <= 24'h000000;
         crc_value <= 16'h0000;
      end else if (dot_en) begin
         dac_data <= mux_out;
         test_data <= mux_out;
         crc_value <= crc_next;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pointer_out <= `CPA_PTR_RESET;
      end else begin
         pointer_out <= palette_pointer_reg;
      end
   end

   property p_blue_wr_inc;
      @(posedge clk_sys) disable iff (rst)
      ram_wr |=> palette_pointer_reg == $past(palette_pointer_reg) + 8'h01;
   endproperty
   a_blue_wr_inc: assert property (p_blue_wr_inc)
      else $error("pointer did not advance after blue write");

   property p_wrap;
      @(posedge clk_sys) disable iff (rst)
      (ram_wr && palette_pointer_reg == 8'hFF) |=>
         palette_pointer_reg == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("pointer did not wrap to zero");

   property p_rd_mode;
      @(posedge clk_sys) disable iff (rst)
      (cpu_wr && sel == `CPA_SEL_PTR_RD) |=> ##1
         palette_pointer_reg == $past(cpu_wdata, 2) + 8'h01;
   endproperty
   a_rd_mode: assert property (p_rd_mode)
      else $error("read mode load did not increment pointer");

   property p_seq_reset;
      @(posedge clk_sys) disable iff (rst)
      wr_ptr_any |=> comp_reg == cpa_pkg::CPA_RED;
   endproperty
   a_seq_reset: assert property (p_seq_reset)
      else $error("sequencer not back at red");

   property p_six_bit_rd;
      @(posedge clk_sys) disable iff (rst)
      (hold_rd && !mode_8bit) |=> cpu_rdata[7:6] == 2'b00;
   endproperty
   a_six_bit_rd: assert property (p_six_bit_rd)
      else $error("6-bit readback MSBs not zero");

   property p_six_bit_out;
      @(posedge clk_sys) disable iff (rst)
      (dot_en && !mode_8bit) |=> dac_data[1:0] == 2'b00 &&
         dac_data[9:8] == 2'b00 && dac_data[17:16] == 2'b00;
   endproperty
   a_six_bit_out: assert property (p_six_bit_out)
      else $error("6-bit output LSBs not zero");

   property p_test_tap;
      @(posedge clk_sys) disable iff (rst)
      dot_en |=> test_data == dac_data;
   endproperty
   a_test_tap: assert property (p_test_tap)
      else $error("test tap differs from dac data");

   property p_page4;
      @(posedge clk_sys) disable iff (rst)
      planes == cpa_pkg::CPA_PLANES_4 |->
         lookup_addr[7:4] == palette_page_select_reg[7:4];
   endproperty
   a_page4: assert property (p_page4)
      else $error("page bits missing in four-plane mode");

   property p_mask;
      @(posedge clk_sys) disable iff (rst)
      (!direct_colour && planes == cpa_pkg::CPA_PLANES_8) |->
         lookup_addr == (pixel_in & pixel_plane_mask_reg);
   endproperty
   a_mask: assert property (p_mask)
      else $error("mask not applied to pixel address");
endmodule
